// ### dv/switch_port_forwarding_control_tb_top.sv
// Self-checking bench of the switch port forwarding control block
`timescale 1ns/1ps
`default_nettype none
module switch_port_forwarding_control_tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [16:0] paddr = 17'h00000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr;
  logic [6:0]  txqAlloc = 7'h00, txqFree = 7'h00, decFwdMask;
  logic        frmValid = 1'b0, frmTagged = 1'b0, frmVlanMember = 1'b0, frmCongested = 1'b0;
  logic [2:0]  frmPort = 3'h0;
  logic [11:0] frmVid = 12'h000, frmPvid = 12'h000, decLookupVid;
  logic [1:0]  frmPrio = 2'h0;
  logic [47:0] frmSrcMac = 48'h000000000000;
  logic        decValid, decDrop, decFlowCtrl, decMacAuth, er;
  logic [31:0] rd;
  int          n_mismatch = 0, checks = 0;

  // 20 MHz core clock
  always #25 mclk = ~mclk;

  switch_port_forwarding_control u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txqAlloc(txqAlloc), .txqFree(txqFree),
    .frmValid(frmValid), .frmPort(frmPort), .frmTagged(frmTagged), .frmVid(frmVid),
    .frmPvid(frmPvid), .frmPrio(frmPrio), .frmSrcMac(frmSrcMac), .frmVlanMember(frmVlanMember),
    .frmCongested(frmCongested), .decValid(decValid), .decDrop(decDrop),
    .decFlowCtrl(decFlowCtrl), .decLookupVid(decLookupVid), .decFwdMask(decFwdMask),
    .decMacAuth(decMacAuth));

  // Single comparison point
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic [2:0] p, input logic [11:0] idx, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {p, idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] p, input logic [11:0] idx, input logic [31:0] exp);
    apb(p, idx, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // One frame descriptor; decision is left standing for the caller to judge
  task automatic frm(input logic [2:0] p, input logic tg, input logic [11:0] v, pv,
                     input logic [1:0] pr, input logic [47:0] sa, input logic mb, cg);
    @(posedge mclk);
    frmValid <= 1'b1;
    frmPort <= p;
    frmTagged <= tg;
    frmVid <= v;
    frmPvid <= pv;
    frmPrio <= pr;
    frmSrcMac <= sa;
    frmVlanMember <= mb;
    frmCongested <= cg;
    @(posedge mclk);
    frmValid <= 1'b0;
    #1;
    chk(decValid, 1'b1);
  endtask

  // Reset values on first and last port, instance zero
  task automatic t_reset;
    logic [11:0] ix [6] = '{spfc_pkg::IDX_DROP_POLICY, spfc_pkg::IDX_FWD_MEMBER,
      spfc_pkg::IDX_TXQ_USAGE, spfc_pkg::IDX_LOOKUP_OPT, spfc_pkg::IDX_INST_SEL,
      spfc_pkg::IDX_MSTP_STATE};
    logic [31:0] ex [6] = '{32'h0, 32'h7F, 32'h0, 32'h0, 32'h0, 32'h6};
    foreach (ix[i]) begin
      rdc(3'h1, ix[i], ex[i]);
      rdc(3'h7, ix[i], ex[i]);
    end
    $display("test reset done");
  endtask

  // Instance pointer steers the state register; reserved bits
  task automatic t_mstp;
    for (int i = 0; i < 8; i++) begin
      apb(3'h1, spfc_pkg::IDX_INST_SEL, 1'b1, {24'h0, 5'h1F, i[2:0]});
      apb(3'h1, spfc_pkg::IDX_MSTP_STATE, 1'b1, {24'h0, 5'h1F, i[2:0]});
    end
    for (int i = 0; i < 8; i++) begin
      apb(3'h1, spfc_pkg::IDX_INST_SEL, 1'b1, {24'h0, 5'h00, i[2:0]});
      rdc(3'h1, spfc_pkg::IDX_MSTP_STATE, {29'h0, i[2:0]});
    end
    apb(3'h1, spfc_pkg::IDX_INST_SEL, 1'b1, 32'hFD);
    rdc(3'h1, spfc_pkg::IDX_INST_SEL, 32'hFD);
    apb(3'h2, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'hFF);
    rdc(3'h2, spfc_pkg::IDX_LOOKUP_OPT, 32'hFA);
    apb(3'h2, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h00);
    $display("test mstp done");
  endtask

  // Refused and ignored accesses
  task automatic t_refuse;
    apb(3'h1, 12'hA08, 1'b0, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(3'h0, 12'h003, 1'b1, 32'h1);
    chk(er, 1'b1);
    apb(3'h1, spfc_pkg::IDX_TXQ_USAGE, 1'b1, 32'h7FF);
    rdc(3'h1, spfc_pkg::IDX_TXQ_USAGE, 32'h0);
    pstrb <= 4'hE;
    apb(3'h1, spfc_pkg::IDX_DROP_POLICY, 1'b1, 32'h3);
    pstrb <= 4'hF;
    rdc(3'h1, spfc_pkg::IDX_DROP_POLICY, 32'h0);
    $display("test refuse done");
  endtask

  // Every drop policy against every priority while congested
  task automatic t_drop;
    for (int pol = 0; pol < 4; pol++) begin
      apb(3'h2, spfc_pkg::IDX_DROP_POLICY, 1'b1, pol);
      for (int pr = 0; pr < 4; pr++) begin
        frm(3'h2, 1'b0, 12'h005, 12'h005, pr[1:0], 48'h1, 1'b1, 1'b1);
        chk({decDrop, decFlowCtrl}, {pol != 0 && pr < pol, pol == 0});
      end
      frm(3'h2, 1'b0, 12'h005, 12'h005, 2'h0, 48'h1, 1'b1, 1'b0);
      chk({decDrop, decFlowCtrl}, 2'b00);
    end
    frm(3'h0, 1'b0, 12'h005, 12'h005, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decDrop, 1'b1);
    $display("test drop done");
  endtask

  // Forward mask is per port and blind to tags
  task automatic t_fwd;
    apb(3'h4, spfc_pkg::IDX_FWD_MEMBER, 1'b1, 32'h15);
    frm(3'h4, 1'b1, 12'h123, 12'h005, 2'h3, 48'h1, 1'b0, 1'b0);
    chk(decFwdMask, 7'h15);
    frm(3'h4, 1'b0, 12'h000, 12'h777, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decFwdMask, 7'h15);
    frm(3'h5, 1'b1, 12'h123, 12'h005, 2'h3, 48'h1, 1'b0, 1'b0);
    chk(decFwdMask, 7'h7F);
    $display("test fwd done");
  endtask

  // Lookup option bits one at a time
  task automatic t_lookup;
    frm(3'h3, 1'b1, 12'h000, 12'h005, 2'h3, 48'h1, 1'b0, 1'b0);
    chk({decLookupVid, decDrop, decMacAuth}, {12'h005, 2'b00});
    apb(3'h3, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h80);
    frm(3'h3, 1'b1, 12'h000, 12'h005, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decLookupVid, 12'h000);
    apb(3'h3, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h40);
    frm(3'h3, 1'b1, 12'h009, 12'h009, 2'h3, 48'h1, 1'b0, 1'b0);
    chk(decDrop, 1'b1);
    frm(3'h3, 1'b1, 12'h009, 12'h009, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decDrop, 1'b0);
    apb(3'h3, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h20);
    frm(3'h3, 1'b1, 12'h009, 12'h005, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decDrop, 1'b1);
    frm(3'h3, 1'b1, 12'h005, 12'h005, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decDrop, 1'b0);
    apb(3'h3, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h10);
    frm(3'h3, 1'b0, 12'h005, 12'h005, 2'h3, 48'h1, 1'b1, 1'b0);
    chk(decMacAuth, 1'b1);
    apb(3'h0, 12'h001, 1'b1, 32'h2C3D4E5F);
    apb(3'h0, 12'h002, 1'b1, 32'h00000A1B);
    rdc(3'h0, 12'h002, 32'h00000A1B);
    apb(3'h3, spfc_pkg::IDX_LOOKUP_OPT, 1'b1, 32'h08);
    frm(3'h3, 1'b0, 12'h005, 12'h005, 2'h3, 48'h0A1B2C3D4E5F, 1'b1, 1'b0);
    chk(decDrop, 1'b0);
    apb(3'h0, 12'h000, 1'b1, 32'h1);
    rdc(3'h0, 12'h000, 32'h00000001);
    frm(3'h3, 1'b0, 12'h005, 12'h005, 2'h3, 48'h0A1B2C3D4E5F, 1'b1, 1'b0);
    chk(decDrop, 1'b1);
    frm(3'h3, 1'b0, 12'h005, 12'h005, 2'h3, 48'h0A1B2C3D4E5E, 1'b1, 1'b0);
    chk(decDrop, 1'b0);
    $display("test lookup done");
  endtask

  // Queue block count follows alloc and free pulses, floor at zero
  task automatic t_txq;
    repeat (3) @(posedge mclk) txqAlloc <= 7'h20;
    @(posedge mclk) txqAlloc <= 7'h00;
    rdc(3'h6, spfc_pkg::IDX_TXQ_USAGE, 32'h3);
    rdc(3'h1, spfc_pkg::IDX_TXQ_USAGE, 32'h0);
    @(posedge mclk) begin
      txqAlloc <= 7'h20;
      txqFree <= 7'h20;
    end
    @(posedge mclk) txqAlloc <= 7'h00;
    repeat (4) @(posedge mclk) txqFree <= 7'h20;
    @(posedge mclk) txqFree <= 7'h00;
    rdc(3'h6, spfc_pkg::IDX_TXQ_USAGE, 32'h0);
    $display("test txq done");
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_mismatch++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_mstp;
    t_refuse;
    t_drop;
    t_fwd;
    t_lookup;
    t_txq;
    complete_run;
  end
endmodule
`default_nettype wire

// ### rtl/spfc_cfg_if.sv
// Settings of the ingress port handed to the lookup check
`timescale 1ns/1ps
`default_nettype none
interface spfc_cfg_if;
  logic       portOk;
  logic [1:0] dropPolicy;
  logic [6:0] fwdMask;
  logic [7:0] lookupOpt;
  modport src (output portOk, dropPolicy, fwdMask, lookupOpt);
  modport chk (input portOk, dropPolicy, fwdMask, lookupOpt);
endinterface
`default_nettype wire

// ### rtl/spfc_lookup_check.sv
// Address lookup option checks for one received frame
`timescale 1ns/1ps
`default_nettype none
module spfc_lookup_check (
  spfc_cfg_if.chk            cfg,
  input  wire logic          frmTagged,
  input  wire logic [11:0]   frmVid,
  input  wire logic [11:0]   frmPvid,
  input  wire logic          frmVlanMember,
  input  wire logic [47:0]   frmSrcMac,
  input  wire logic [47:0]   switchMac,
  input  wire logic          globalSaEn,
  output logic [11:0]        lookupVid,
  output logic               filterDrop,
  output logic               selfDrop,
  output logic               macAuth
);
  logic useFrameVid;

  // Priority tagged frames fall back to the default VID unless told not to
  assign useFrameVid = frmTagged && (frmVid != spfc_pkg::VID_NULL
    || cfg.lookupOpt[spfc_pkg::LK_NULL_VID]);
  assign lookupVid = useFrameVid ? frmVid : frmPvid;

  // Membership and default VID filters
  assign filterDrop = (cfg.lookupOpt[spfc_pkg::LK_VLAN_FILT] && !frmVlanMember)
    || (cfg.lookupOpt[spfc_pkg::LK_NON_PVID] && lookupVid != frmPvid);

  // Own address filter needs both the port and the global enable
  assign selfDrop = cfg.lookupOpt[spfc_pkg::LK_SELF_FILT] && globalSaEn
    && frmSrcMac == switchMac;
  assign macAuth = cfg.lookupOpt[spfc_pkg::LK_MAC_AUTH];
endmodule
`default_nettype wire

// ### rtl/spfc_pkg.sv
// Constants of the switch port forwarding control block
package spfc_pkg;
  localparam int NUM_PORTS  = 7;
  localparam int MSTP_COUNT = 8;
  // Register indices inside one port space; byte address is four times this
  localparam logic [11:0] IDX_DROP_POLICY = 12'hA00;
  localparam logic [11:0] IDX_FWD_MEMBER  = 12'hA04;
  localparam logic [11:0] IDX_TXQ_USAGE   = 12'hA10;
  localparam logic [11:0] IDX_LOOKUP_OPT  = 12'hB00;
  localparam logic [11:0] IDX_INST_SEL    = 12'hB01;
  localparam logic [11:0] IDX_MSTP_STATE  = 12'hB04;
  // Global registers, in port space zero
  localparam logic [11:0] IDX_GLOBAL_CTRL = 12'h000;
  localparam logic [11:0] IDX_MAC_LO      = 12'h001;
  localparam logic [11:0] IDX_MAC_HI      = 12'h002;
  localparam logic [2:0]  PORT_GLOBAL     = 3'h0;
  // Values after reset
  localparam logic [1:0]  DROP_RST   = 2'h0;
  localparam logic [6:0]  FWD_RST    = 7'h7F;
  localparam logic [10:0] TXQ_RST    = 11'h000;
  localparam logic [10:0] TXQ_MAX    = 11'h7FF;
  localparam logic [7:0]  LOOKUP_RST = 8'h00;
  localparam logic [7:0]  SEL_RST    = 8'h00;
  localparam logic [2:0]  MSTP_RST   = 3'h6;
  localparam logic [47:0] MAC_RST    = 48'h0000_0000_0000;
  // Writable bits of the lookup options; others read zero
  localparam logic [7:0]  LOOKUP_RW_MASK = 8'hFA;
  // Lookup option bit positions
  localparam int LK_NULL_VID   = 7;
  localparam int LK_VLAN_FILT  = 6;
  localparam int LK_NON_PVID   = 5;
  localparam int LK_MAC_AUTH   = 4;
  localparam int LK_SELF_FILT  = 3;
  localparam int GC_SELF_FILT  = 0;
  localparam logic [1:0]  DROP_NONE = 2'h0;
  localparam logic [11:0] VID_NULL  = 12'h000;
endpackage

// ### rtl/spfc_port_regs.sv
// Register set of one switch port
`timescale 1ns/1ps
`default_nettype none
module spfc_port_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic [11:0] wrIdx,
  input  wire logic [7:0]  wdata,
  input  wire logic        txqAlloc,
  input  wire logic        txqFree,
  output logic [1:0]       dropPolicy,
  output logic [6:0]       fwdMask,
  output logic [7:0]       lookupOpt,
  output logic [7:0]       instSel,
  output logic [2:0]       mstpState,
  output logic [10:0]      txqBlocks
);
  typedef struct packed {
    logic [1:0]      dropPolicy;
    logic [6:0]      fwdMask;
    logic [7:0]      lookupOpt;
    logic [7:0]      instSel;
    logic [7:0][2:0] mstp;
    logic [10:0]     txqBlocks;
  } spfc_port_state_t;
  localparam spfc_port_state_t ST_RST = '{spfc_pkg::DROP_RST, spfc_pkg::FWD_RST,
    spfc_pkg::LOOKUP_RST, spfc_pkg::SEL_RST, {spfc_pkg::MSTP_COUNT{spfc_pkg::MSTP_RST}},
    spfc_pkg::TXQ_RST};
  spfc_port_state_t st;
  spfc_port_state_t next_st;
  logic [2:0]       wMstp;
  assign wMstp = wdata[2:0];

  // Register writes and the queue block counter
  always_comb begin
    next_st = st;
    if (wrEn) begin
      case (wrIdx)
        spfc_pkg::IDX_DROP_POLICY: next_st.dropPolicy = wdata[1:0];
        spfc_pkg::IDX_FWD_MEMBER:  next_st.fwdMask = wdata[6:0];
        spfc_pkg::IDX_LOOKUP_OPT:  next_st.lookupOpt = wdata & spfc_pkg::LOOKUP_RW_MASK;
        spfc_pkg::IDX_INST_SEL:    next_st.instSel = wdata;
        spfc_pkg::IDX_MSTP_STATE:  next_st.mstp[st.instSel[2:0]] = wMstp;
        default: ;
      endcase
    end
    // Saturate rather than wrap, a wrapped count would mislead software
    if (txqAlloc && !txqFree && st.txqBlocks != spfc_pkg::TXQ_MAX) begin
      next_st.txqBlocks = st.txqBlocks + 11'h001;
    end else if (txqFree && !txqAlloc && st.txqBlocks != spfc_pkg::TXQ_RST) begin
      next_st.txqBlocks = st.txqBlocks - 11'h001;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign dropPolicy = st.dropPolicy;
  assign fwdMask    = st.fwdMask;
  assign lookupOpt  = st.lookupOpt;
  assign instSel    = st.instSel;
  assign mstpState  = st.mstp[st.instSel[2:0]];
  assign txqBlocks  = st.txqBlocks;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_fwd_reset_ones: assert property ($fell(rst) |-> fwdMask == 7'h7F)
    else $error("forward mask not all ones after reset");
  a_txq_reset_zero: assert property ($fell(rst) |-> txqBlocks == 11'h000)
    else $error("queue block count not zero after reset");
  a_txq_count_up: assert property (txqAlloc && !txqFree && txqBlocks != 11'h7FF
    |=> txqBlocks == $past(txqBlocks) + 11'h001)
    else $error("queue block count missed an allocation");
  a_mstp_indexed: assert property (wrEn && wrIdx == 12'hB04
    |=> mstpState == $past(wMstp))
    else $error("spanning state write missed the selected instance");
  a_mstp_reset_val: assert property ($fell(rst) |-> mstpState == 3'h6)
    else $error("spanning state reset value wrong");
endmodule
`default_nettype wire

// ### rtl/switch_port_forwarding_control.sv
// Per-port forwarding control registers with APB access and frame decisions
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module switch_port_forwarding_control (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [16:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  txqAlloc,
  input  wire logic [6:0]  txqFree,
  input  wire logic        frmValid,
  input  wire logic [2:0]  frmPort,
  input  wire logic        frmTagged,
  input  wire logic [11:0] frmVid,
  input  wire logic [11:0] frmPvid,
  input  wire logic [1:0]  frmPrio,
  input  wire logic [47:0] frmSrcMac,
  input  wire logic        frmVlanMember,
  input  wire logic        frmCongested,
  output logic             decValid,
  output logic             decDrop,
  output logic             decFlowCtrl,
  output logic [11:0]      decLookupVid,
  output logic [6:0]       decFwdMask,
  output logic             decMacAuth
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        globalSaEn;
    logic [47:0] switchMac;
    logic        decValid;
    logic        decDrop;
    logic        decFlowCtrl;
    logic [11:0] decLookupVid;
    logic [6:0]  decFwdMask;
    logic        decMacAuth;
    logic        dropCong;
    logic        dropSelf;
  } spfc_top_state_t;

  spfc_top_state_t st;
  spfc_top_state_t next_st;

  // Per-port register outputs, entry g belongs to port g+1
  logic [spfc_pkg::NUM_PORTS-1:0][1:0]  pDrop;
  logic [spfc_pkg::NUM_PORTS-1:0][6:0]  pFwd;
  logic [spfc_pkg::NUM_PORTS-1:0][7:0]  pLook;
  logic [spfc_pkg::NUM_PORTS-1:0][7:0]  pSel;
  logic [spfc_pkg::NUM_PORTS-1:0][2:0]  pMstp;
  logic [spfc_pkg::NUM_PORTS-1:0][10:0] pTxq;
  logic [spfc_pkg::NUM_PORTS-1:0]       portWr;

  // Bus decode
  logic [2:0]  port;
  logic [11:0] off;
  logic [2:0]  pIx;
  logic        setup;
  logic        access;
  logic        mapped;
  logic [31:0] rdData;
  logic        busWr;

  // Frame side
  logic [2:0]  fIx;
  logic [11:0] lookupVid;
  logic        filterDrop;
  logic        selfDrop;
  logic        macAuth;
  logic        congDrop;
  logic        flowCtrl;

  spfc_cfg_if cfg ();

  assign port   = paddr[16:14];
  assign off    = paddr[13:2];
  assign pIx    = port - 3'h1;
  assign setup  = psel && !penable;
  assign access = psel && penable && st.pready;
  // Errored transfers never write, so a bad address cannot corrupt state
  assign busWr  = access && pwrite && !st.pslverr;

  // Read multiplexer, also tells whether the address is mapped
  always_comb begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    if (port == spfc_pkg::PORT_GLOBAL) begin
      case (off)
        spfc_pkg::IDX_GLOBAL_CTRL: rdData = {31'h0, st.globalSaEn};
        spfc_pkg::IDX_MAC_LO:      rdData = st.switchMac[31:0];
        spfc_pkg::IDX_MAC_HI:      rdData = {16'h0, st.switchMac[47:32]};
        default:                   mapped = 1'b0;
      endcase
    end else begin
      case (off)
        spfc_pkg::IDX_DROP_POLICY: rdData = {30'h0, pDrop[pIx]};
        spfc_pkg::IDX_FWD_MEMBER:  rdData = {25'h0, pFwd[pIx]};
        spfc_pkg::IDX_TXQ_USAGE:   rdData = {21'h0, pTxq[pIx]};
        spfc_pkg::IDX_LOOKUP_OPT:  rdData = {24'h0, pLook[pIx]};
        spfc_pkg::IDX_INST_SEL:    rdData = {24'h0, pSel[pIx]};
        spfc_pkg::IDX_MSTP_STATE:  rdData = {29'h0, pMstp[pIx]};
        default:                   mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  // One copy of the register set for each switch port
  genvar g;
  generate
    for (g = 0; g < spfc_pkg::NUM_PORTS; g = g + 1) begin : gPort
      assign portWr[g] = busWr && pstrb[0] && port == 3'(g + 1);
      spfc_port_regs uRegs (
        .mclk       (mclk),
        .rst        (rst),
        .wrEn       (portWr[g]),
        .wrIdx      (off),
        .wdata      (pwdata[7:0]),
        .txqAlloc   (txqAlloc[g]),
        .txqFree    (txqFree[g]),
        .dropPolicy (pDrop[g]),
        .fwdMask    (pFwd[g]),
        .lookupOpt  (pLook[g]),
        .instSel    (pSel[g]),
        .mstpState  (pMstp[g]),
        .txqBlocks  (pTxq[g])
      );
    end
  endgenerate

  // Settings of the port that the current frame arrived on
  assign fIx            = frmPort - 3'h1;
  assign cfg.portOk     = frmPort != 3'h0;
  assign cfg.dropPolicy = cfg.portOk ? pDrop[fIx] : spfc_pkg::DROP_NONE;
  assign cfg.fwdMask    = cfg.portOk ? pFwd[fIx] : 7'h00;
  assign cfg.lookupOpt  = cfg.portOk ? pLook[fIx] : 8'h00;

  spfc_lookup_check uCheck (
    .cfg           (cfg),
    .frmTagged     (frmTagged),
    .frmVid        (frmVid),
    .frmPvid       (frmPvid),
    .frmVlanMember (frmVlanMember),
    .frmSrcMac     (frmSrcMac),
    .switchMac     (st.switchMac),
    .globalSaEn    (st.globalSaEn),
    .lookupVid     (lookupVid),
    .filterDrop    (filterDrop),
    .selfDrop      (selfDrop),
    .macAuth       (macAuth)
  );

  // Congestion handling: low priorities are dropped below the policy level
  assign congDrop = frmCongested && cfg.dropPolicy != spfc_pkg::DROP_NONE
    && frmPrio < cfg.dropPolicy;
  assign flowCtrl = frmCongested && cfg.dropPolicy == spfc_pkg::DROP_NONE;

  // Next state: bus answer, global settings and the frame decision
  always_comb begin
    next_st = st;
    // Answer in the first access cycle, data fixed during setup
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = !mapped;
      next_st.prdata  = (!pwrite && mapped) ? rdData : 32'h0000_0000;
    end
    if (busWr && port == spfc_pkg::PORT_GLOBAL) begin
      if (off == spfc_pkg::IDX_GLOBAL_CTRL && pstrb[0]) begin
        next_st.globalSaEn = pwdata[spfc_pkg::GC_SELF_FILT];
      end
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b] && off == spfc_pkg::IDX_MAC_LO) begin
          next_st.switchMac[8*b +: 8] = pwdata[8*b +: 8];
        end
      end
      // Upper word holds only two address bytes, so the loop stops early
      for (int b = 0; b < 2; b++) begin
        if (pstrb[b] && off == spfc_pkg::IDX_MAC_HI) begin
          next_st.switchMac[32 + 8*b +: 8] = pwdata[8*b +: 8];
        end
      end
    end
    // Unknown port numbers are dropped so nothing escapes unchecked
    next_st.decValid     = frmValid;
    next_st.decLookupVid = frmValid ? lookupVid : 12'h000;
    next_st.decFwdMask   = frmValid ? cfg.fwdMask : 7'h00;
    next_st.decMacAuth   = frmValid && macAuth;
    next_st.decFlowCtrl  = frmValid && cfg.portOk && flowCtrl;
    next_st.dropCong     = frmValid && cfg.portOk && congDrop;
    next_st.dropSelf     = frmValid && cfg.portOk && selfDrop;
    next_st.decDrop      = frmValid && (!cfg.portOk || congDrop || filterDrop
      || selfDrop);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.switchMac <= spfc_pkg::MAC_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign decValid     = st.decValid;
  assign decDrop      = st.decDrop;
  assign decFlowCtrl  = st.decFlowCtrl;
  assign decLookupVid = st.decLookupVid;
  assign decFwdMask   = st.decFwdMask;
  assign decMacAuth   = st.decMacAuth;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Bus handshake steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  // Accepted write of one port's forward mask
  sequence s_fwd_write;
    psel && penable && pready && pwrite && pstrb[0] && !pslverr
      && port != 3'h0 && off == 12'hA04;
  endsequence

  // Bus answer timing, refusal and read path
  a_apb_answer: assert property (s_setup |=> s_answer ##1 !pready)
    else $error("bus answer not in first access cycle");

  a_apb_unmapped: assert property (s_setup and (paddr[1:0] != 2'h0) |=> pslverr && pready)
    else $error("misaligned access not refused");

  a_apb_idle_quiet: assert property (!psel |=> !pready)
    else $error("bus answered without a request");

  a_err_data_zero: assert property (s_setup and (!mapped)
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("refused access returned data");

  a_reserved_zero: assert property (pready && port != 3'h0 && off == 12'hA10
    |-> prdata[31:11] == 21'h0)
    else $error("reserved queue count bits not zero");

  a_txq_read: assert property (s_setup and (!pwrite && off == 12'hA10)
    and (port != 3'h0 && paddr[1:0] == 2'h0) |=> prdata[10:0] == $past(pTxq[pIx]))
    else $error("queue block count read wrong");

  a_fwd_write: assert property (s_fwd_write |=> pFwd[$past(pIx)] == $past(pwdata[6:0]))
    else $error("forward mask write did not land");

  // Congestion policy; a frame from port zero never reaches it
  a_no_drop_flow: assert property (frmValid && cfg.portOk && frmCongested
    && cfg.dropPolicy == 2'h0 |=> decFlowCtrl && !st.dropCong)
    else $error("policy zero dropped or gave no flow control");

  a_prio_drop: assert property (frmValid && cfg.portOk && frmCongested
    && cfg.dropPolicy != 2'h0 && frmPrio < cfg.dropPolicy |=> decDrop && !decFlowCtrl)
    else $error("congestion drop by priority wrong");

  a_prio_keep: assert property (frmValid && cfg.portOk && frmPrio >= cfg.dropPolicy
    |=> !st.dropCong)
    else $error("frame above policy level dropped");

  a_calm_no_flow: assert property (frmValid && !frmCongested
    |=> !decFlowCtrl && !st.dropCong)
    else $error("flow control or drop without congestion");

  a_dec_quiet: assert property (!frmValid |=> !decValid && !decDrop && decFwdMask == 7'h00)
    else $error("decision outputs active without a frame");

  a_bad_port_drop: assert property (frmValid && frmPort == 3'h0 |=> decDrop && !decFlowCtrl)
    else $error("frame of unknown port not dropped");

  // Lookup options of the ingress port
  a_fwd_port_only: assert property (frmValid ##1 decValid
    |-> decFwdMask == $past(cfg.fwdMask))
    else $error("forward mask not taken from port setting");

  a_frame_vid: assert property (frmValid && frmTagged && frmVid != 12'h000
    |=> decLookupVid == $past(frmVid))
    else $error("tagged frame lookup did not use its VID");

  a_null_vid: assert property (frmValid && frmTagged && frmVid == 12'h000
    && !cfg.lookupOpt[7] |=> decLookupVid == $past(frmPvid))
    else $error("null VID lookup did not use default VID");

  a_null_vid_on: assert property (frmValid && frmTagged && frmVid == 12'h000
    && cfg.lookupOpt[7] |=> decLookupVid == 12'h000)
    else $error("null VID lookup did not use VID zero");

  a_vlan_filter: assert property (frmValid && cfg.lookupOpt[6] && !frmVlanMember
    |=> decDrop)
    else $error("non-member frame not filtered");

  a_non_pvid: assert property (frmValid && cfg.lookupOpt[5] && frmTagged
    && frmVid != 12'h000 && frmVid != frmPvid |=> decDrop)
    else $error("foreign VID frame not dropped");

  a_mac_auth: assert property (frmValid |=> decMacAuth == $past(cfg.lookupOpt[4]))
    else $error("authentication mode not passed on");

  a_self_hit: assert property (frmValid && cfg.portOk && cfg.lookupOpt[3]
    && st.globalSaEn && frmSrcMac == st.switchMac |=> st.dropSelf && decDrop)
    else $error("own source address not dropped");

  a_self_miss: assert property (frmValid && frmSrcMac != st.switchMac |=> !st.dropSelf)
    else $error("foreign source address dropped as own");

  a_self_gate: assert property (frmValid && !(cfg.lookupOpt[3] && st.globalSaEn)
    |=> !st.dropSelf)
    else $error("self filter active without both enables");
endmodule
`default_nettype wire
